// *** hw/osw_top.sv ***
// oscillation stabilization wait after stop-state release
`timescale 1ns/1ns
// =====================================================================
// What this block does
// - hold cpu until wait ends on crystal
// - select code picks 2^11 or 2^13..2^16 cycle wait
// - reset loads select register with 05h
// - counter saturates at chosen wait
// - count only after oscillation starts
module osw_top
    import osw_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire osw_pkg::osw_bus_type bus,
    output logic [7:0] rdata,
    input wire logic stop_enter,
    input wire logic stop_release,
    input wire logic osc_started,
    input wire logic cpu_on_crystal,
    output logic cpu_hold,
    output logic stab_done,
    output logic [osw_pkg::count_width-1:0] stab_status_counter
);
    import osw_pkg::*;

    // =================================================================
    // registers
    logic [sel_width-1:0] stab_wait_select;
    logic [count_width-1:0] limit;
    osw_state_type state;
    logic sel_hit;

    assign sel_hit = bus.addr == stab_wait_select_addr;

    // only byte writes exist on this port, so no bit-level path is offered
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stab_wait_select <= stab_wait_select_reset[sel_msb:0];
        end else if (bus.wr && sel_hit) begin
            stab_wait_select <= bus.wdata[sel_msb:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata <= 8'h00;
        end else if (bus.rd && sel_hit) begin
            rdata <= {5'h00, stab_wait_select};
        end else begin
            rdata <= 8'h00;
        end
    end

    osw_wait_decode u_decode (
        .sel(stab_wait_select),
        .limit(limit)
    );

    // =================================================================
    // sequencing
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= osw_run;
        end else begin
            case (state)
                osw_run: begin
                    if (stop_enter) begin
                        state <= osw_stop;
                    end
                end
                osw_stop: begin
                    if (stop_release) begin
                        state <= osw_settle;
                    end
                end
                osw_settle: begin
                    if (stab_status_counter >= limit) begin
                        state <= osw_run;
                    end
                end
                default: state <= osw_run;
            endcase
        end
    end

    // =================================================================
    // stabilization counter, one count per crystal cycle (clk)
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stab_status_counter <= '0;
        end else if (state == osw_run && stop_enter) begin
            stab_status_counter <= '0;
        end else if (state != osw_run && osc_started) begin
            if (stab_status_counter < limit) begin
                stab_status_counter <= stab_status_counter + 17'h00001;
            end else begin
                stab_status_counter <= limit;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stab_done <= 1'b0;
        end else if (state == osw_run && stop_enter) begin
            stab_done <= 1'b0;
        end else if (stab_status_counter >= limit) begin
            stab_done <= 1'b1;
        end
    end

    // internal-osc cpu is never held; software polls the counter instead
    assign cpu_hold = cpu_on_crystal && (state == osw_stop || state == osw_settle);
endmodule

// *** hw/osw_pkg.sv ***
// package: register map, field layout, reset value and wait codes for the stabilization wait
package osw_pkg;
    localparam logic [15:0] stab_wait_select_addr = 16'hffa4;
    localparam logic [7:0] stab_wait_select_reset = 8'h05;
    localparam int sel_msb = 2;
    localparam int sel_width = 3;
    localparam int count_width = 17;
    localparam logic [2:0] sel_2e11 = 3'h1;
    localparam logic [2:0] sel_2e13 = 3'h2;
    localparam logic [2:0] sel_2e14 = 3'h3;
    localparam logic [2:0] sel_2e15 = 3'h4;
    localparam logic [2:0] sel_2e16 = 3'h5;
    localparam logic [16:0] wait_2e11 = 17'h00800;
    localparam logic [16:0] wait_2e13 = 17'h02000;
    localparam logic [16:0] wait_2e14 = 17'h04000;
    localparam logic [16:0] wait_2e15 = 17'h08000;
    localparam logic [16:0] wait_2e16 = 17'h10000;
    // crystal is 10 MHz nominal; wait times in microseconds for reference
    localparam real wait_2e11_us = 204.8;
    localparam real wait_2e13_us = 819.2;
    localparam real wait_2e16_us = 6550.0;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } osw_bus_type;

    typedef enum logic [1:0] {
        osw_run,
        osw_stop,
        osw_settle
    } osw_state_type;
endpackage

// *** hw/osw_wait_decode.sv ***
// decode of the wait select field into a terminal cycle count
`timescale 1ns/1ns
module osw_wait_decode
    import osw_pkg::*;
(
    input wire logic [osw_pkg::sel_width-1:0] sel,
    output logic [osw_pkg::count_width-1:0] limit
);
    always_comb begin
        case (sel)
            sel_2e11: limit = wait_2e11;
            sel_2e13: limit = wait_2e13;
            sel_2e14: limit = wait_2e14;
            sel_2e15: limit = wait_2e15;
            sel_2e16: limit = wait_2e16;
            // prohibited codes fall back to the longest wait, the safe side
            default: limit = wait_2e16;
        endcase
    end
endmodule

// *** sim/osw_checker.sv ***
// checker: port assertions for the stabilization wait
`timescale 1ns/1ns
module osw_checker
    import osw_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire osw_pkg::osw_bus_type bus,
    input wire logic [7:0] rdata,
    input wire logic stop_enter,
    input wire logic stop_release,
    input wire logic osc_started,
    input wire logic cpu_on_crystal,
    input wire logic cpu_hold,
    input wire logic stab_done,
    input wire logic [osw_pkg::count_width-1:0] stab_status_counter
);
// ====
// assertions
default clocking @(posedge clk); endclocking
default disable iff (sys_rst);
property p_hold; cpu_hold |-> cpu_on_crystal; endproperty
a_hold: assert property (p_hold) else $error("hold off crystal");
property p_rd; bus.rd && bus.addr == stab_wait_select_addr |=> rdata[7:3] == 5'h0; endproperty
a_rd: assert property (p_rd) else $error("upper bits set");
// reset must be seen while it is high, so this one is never disabled
property p_rst; disable iff (1'b0) sys_rst |=> !stab_done && stab_status_counter == 0; endproperty
a_rst: assert property (p_rst) else $error("reset state");
property p_sat; stab_status_counter <= wait_2e16; endproperty
a_sat: assert property (p_sat) else $error("counter past limit");
property p_osc; !osc_started && !stop_enter |=> $stable(stab_status_counter); endproperty
a_osc: assert property (p_osc) else $error("count without osc");
property p_clr; stop_enter && cpu_on_crystal && !cpu_hold |=> stab_status_counter == 0; endproperty
a_clr: assert property (p_clr) else $error("no clear on stop");
// the counter may be cleared or parked, but never skips ahead
property p_step; stab_status_counter <= $past(stab_status_counter) || stab_status_counter == $past(stab_status_counter) + 17'h00001; endproperty
a_step: assert property (p_step) else $error("counter jumped");
property p_release; $fell(cpu_hold) && cpu_on_crystal |-> stab_done; endproperty
a_release: assert property (p_release) else $error("hold dropped early");
endmodule
bind osw_top osw_checker i_osw_checker(.clk, .sys_rst, .bus, .rdata, .stop_enter, .stop_release,
    .osc_started, .cpu_on_crystal, .cpu_hold, .stab_done, .stab_status_counter);

// *** sim/osw_top_test.sv ***
// testbench: stabilization wait
`timescale 1ns/1ns
module osw_top_test;
import osw_pkg::*;
logic clk = 0, sys_rst = 1, se = 0, sr = 0, osc = 0, xt = 1, hold, done;
osw_bus_type bus = '0;
logic [7:0] q;
logic [16:0] cnt;
int fail_count = 0, compares = 0, n;
logic [7:0] rows [5][2] = '{'{8'h01, 8'h01}, '{8'h02, 8'h02}, '{8'h03, 8'h03},
    '{8'h04, 8'h04}, '{8'hfd, 8'h05}};
always #10 clk = ~clk;
osw_top i_osw_top(.clk(clk), .sys_rst(sys_rst), .bus(bus), .rdata(q), .stop_enter(se),
    .stop_release(sr), .osc_started(osc), .cpu_on_crystal(xt), .cpu_hold(hold),
    .stab_done(done), .stab_status_counter(cnt));
task tick; @(posedge clk); #2; endtask
task chk(input string s, input logic [16:0] e, input logic [16:0] g);
    compares++;
    if (g !== e) begin
        fail_count++;
        $display("[ERR] %s exp %h got %h", s, e, g);
    end
endtask
task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    bus = '{w, !w, a, d};
    tick;
    bus = '0;
endtask
task give_verdict;
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
// ====
// main sequence
initial begin
    repeat (6) tick;
    sys_rst = 0;
    acc(0, stab_wait_select_addr, 0);
    chk("sel", 8'h05, q);
    for (int i = 0; i < 5; i++) begin
        acc(1, stab_wait_select_addr, rows[i][0]);
        acc(0, stab_wait_select_addr, 0);
        chk("sel", rows[i][1], q);
    end
    acc(1, stab_wait_select_addr, 8'h0e);
    acc(0, stab_wait_select_addr, 0);
    chk("prohibited", 8'h06, q);
    acc(0, 16'hffa5, 0);
    chk("unmapped", 0, q);
    acc(1, stab_wait_select_addr, 8'h01);
    se = 1;
    tick;
    se = 0;
    repeat (5) tick;
    chk("no osc", 0, cnt);
    sr = 1;
    osc = 1;
    tick;
    sr = 0; // select left alone during the wait
    n = 1;
    // bounded so a stuck hold ends the run instead of hanging
    while (hold === 1'b1 && n < 70000) begin
        tick;
        n++;
    end
    chk("held", 1, n >= 2048 && n < 2052);
    repeat (50) tick;
    chk("sat", wait_2e11, cnt);
    chk("done", 1, done);
    xt = 0;
    se = 1;
    tick;
    se = 0;
    sr = 1;
    tick;
    sr = 0;
    chk("no hold", 0, hold);
    n = 0;
    // software polls until the counter reaches the programmed wait, giving up after 3000 cycles
    while (cnt !== wait_2e11 && n < 3000) begin
        tick;
        n++;
    end
    chk("poll", 1, n >= 2040 && n < 2050);
    repeat (10) tick;
    chk("poll sat", wait_2e11, cnt);
    chk("poll no hold", 0, hold);
    sys_rst = 1;
    repeat (2) tick;
    sys_rst = 0;
    acc(0, stab_wait_select_addr, 0);
    chk("rst sel", 8'h05, q);
    give_verdict;
end
endmodule
